// ---- design/wrac_pkg.sv ----
// Package of constants and types for the waveform record acquisition controller
// Functional notes
// - Single-slot record length capped at 16K base, 64K deep memory.
// - Double-width module allowed up to 32K base, 128K deep memory.
// - Mixed modules share length up to single max; single stays clamped above.
// - Auto length with manual rate: shortest screen-filling record, floor 256 or 512.
// - Single-width manual length accepted from 16 to 16K base, 65K deep.
// - Four-slot module accepts manual length up to 64K base, 256K deep.
// - Graded, histogram or mask modes with auto length pick own optimum count.
// - Averaging acts only in equivalent-time mode, never in real-time.
// - Average count adjustable from 1 through 4096 inclusive.
// - Bin update is new/n plus (n-1)/n of existing value.
// - Trigger may deposit zero samples; many triggers may fill a record.
// - With completion on, release only when threshold percent of bins are new.
// - With averaging, a bin counts only after full configured average count.
// - With completion on, erase whole record after each release.
// - Real-time mode refills record each trigger; completion behaves as 100%. Here real-time releases at each cycle end, no clear.
// - Completion off: release each cycle, no clearing, bins overwritten as filled.
// - Default-setup or autoscale forces completion off.
package wrac_pkg;

  // ==========================================================================
  // Register map (word offsets as byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_NAVG     = 8'h04;
  localparam logic [7:0] ADDR_LEN      = 8'h08;
  localparam logic [7:0] ADDR_COMPL    = 8'h0c;
  localparam logic [7:0] ADDR_SCREEN   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_ACTLEN   = 8'h18;
  localparam logic [7:0] ADDR_QUAL     = 8'h1c;
  localparam logic [7:0] ADDR_RELCNT   = 8'h20;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_ETIME_BIT   = 0;  // 1 = equivalent-time, 0 = real-time
  localparam int CTRL_AVG_BIT     = 1;
  localparam int CTRL_COMPL_BIT   = 2;
  localparam int CTRL_AUTOLEN_BIT = 3;
  localparam int CTRL_DEEP_BIT    = 4;
  localparam int CTRL_GRADED_BIT  = 5;
  localparam int CTRL_WIDTH_LSB   = 6;  // 2-bit module width code
  localparam int CTRL_DEFAULT_BIT = 8;  // write 1: default setup pulse
  localparam int CTRL_ASCALE_BIT  = 9;  // write 1: autoscale pulse
  localparam int CTRL_CLEAR_BIT   = 10; // write 1: clear record
  localparam logic [31:0] CTRL_RESET = 32'h0000_0009;

  // ==========================================================================
  // Module width codes
  typedef enum logic [1:0] {
    WRAC_SINGLE_TYPE_W = 2'b00,
    WRAC_DOUBLE_TYPE_W = 2'b01,
    WRAC_QUAD_TYPE_W   = 2'b10
  } wrac_width_type;

  // ==========================================================================
  // Record length limits in points
  localparam logic [18:0] LEN_SINGLE_BASE = 19'h04000; // 16K
  localparam logic [18:0] LEN_SINGLE_DEEP = 19'h10000; // 64K
  localparam logic [18:0] LEN_DOUBLE_BASE = 19'h08000; // 32K
  localparam logic [18:0] LEN_DOUBLE_DEEP = 19'h20000; // 128K
  localparam logic [18:0] LEN_QUAD_BASE   = 19'h10000; // 64K
  localparam logic [18:0] LEN_QUAD_DEEP   = 19'h40000; // 256K
  localparam logic [18:0] LEN_MANUAL_MIN  = 19'h00010; // 16
  localparam logic [18:0] LEN_AUTO_SINGLE = 19'h00100; // 256
  localparam logic [18:0] LEN_AUTO_DOUBLE = 19'h00200; // 512
  localparam logic [18:0] LEN_GRADED_OPT  = 19'h00800; // optimum database size
  localparam logic [18:0] LEN_RESET       = 19'h00400;

  // ==========================================================================
  // Averaging and completion
  localparam logic [12:0] NAVG_MIN    = 13'h0001;
  localparam logic [12:0] NAVG_MAX    = 13'h1000; // 4096
  localparam logic [12:0] NAVG_RESET  = 13'h0010;
  localparam logic [6:0]  COMPL_FULL  = 7'h64;    // 100 percent
  localparam logic [6:0]  COMPL_RESET = 7'h5a;    // 90 percent
  localparam logic [18:0] SCREEN_RESET = 19'h003e8;

  typedef enum logic [1:0] {
    WRAC_IDLE_TYPE_S  = 2'b00,
    WRAC_ACQ_TYPE_S   = 2'b01,
    WRAC_CLEAR_TYPE_S = 2'b10
  } wrac_state_type;

endpackage

// ---- design/wrac_bin_if.sv ----
// Interface carrying bin store requests between the controller and the bin store
`timescale 1ns/100ps
interface wrac_bin_if #(
  parameter int AW = 8,
  parameter int DW = 16
);
  logic          wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [12:0]   wcnt;
  logic [DW-1:0] rdata;
  logic [12:0]   rcnt;
  logic          clr;

  modport ctrl  (output wr, addr, wdata, wcnt, clr, input rdata, rcnt);
  modport store (input wr, addr, wdata, wcnt, clr, output rdata, rcnt);
endinterface

// ---- design/wrac_bin_store.sv ----
// Bin store: per-bin averaged value and average count in flip-flops
`timescale 1ns/100ps
module wrac_bin_store #(
  parameter int BINS = 256,
  parameter int AW   = 8,
  parameter int DW   = 16
) (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  wrac_bin_if.store   bin
);
  logic [DW-1:0] val_q [BINS];
  logic [12:0]   cnt_q [BINS];

  // ==========================================================================
  // Storage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < BINS; i++) begin
        val_q[i] <= '0;
        cnt_q[i] <= '0;
      end
    end else if (bin.clr) begin
      for (int i = 0; i < BINS; i++) begin
        cnt_q[i] <= '0;
      end
    end else if (bin.wr) begin
      val_q[bin.addr] <= bin.wdata;
      cnt_q[bin.addr] <= bin.wcnt;
    end
  end

  assign bin.rdata = val_q[bin.addr];
  assign bin.rcnt  = cnt_q[bin.addr];
endmodule

// ---- design/wrac_top.sv ----
// Waveform record acquisition controller with Wishbone register port
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module wrac_top #(
  parameter int BINS = 256,
  parameter int AW   = 8,
  parameter int DW   = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  output logic               wb_err_o,
  input  wire logic          trig_i,
  input  wire logic          cycle_end_i,
  input  wire logic          smp_valid_i,
  input  wire logic [AW-1:0] smp_bin_i,
  input  wire logic [DW-1:0] smp_data_i,
  output logic               smp_ready_o,
  output logic               meas_o,
  output logic               avg_active_o
);
  // ==========================================================================
  // Elaboration checks
  if (BINS < 16 || BINS > (1 << AW)) begin : g_bins_chk
    $error("wrac_top: BINS does not fit AW");
  end
  if (DW < 2) begin : g_dw_chk
    $error("wrac_top: DW too small");
  end

  wrac_bin_if #(.AW(AW), .DW(DW)) bin ();

  wrac_bin_store #(.BINS(BINS), .AW(AW), .DW(DW)) u_store (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bin       (bin)
  );

  // ==========================================================================
  // Registers
  logic [10:0] ctrl_q;
  logic [12:0] navg_q;
  logic [18:0] len_req_q;
  logic [6:0]  compl_q;
  logic [18:0] screen_q;
  logic [31:0] rel_cnt_q;
  logic        wb_ack_q;
  logic [31:0] wb_dat_q;
  logic        wb_err_q;

  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q && !wb_err_q;
  wire logic wb_wr  = wb_req && wb_we_i && (wb_sel_i == 4'hf);

  // Manual length clamp per module width and memory option
  function automatic logic [18:0] wrac_clamp(input logic [18:0] v, input logic [18:0] lo,
                                             input logic [18:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [12:0] wrac_navg_clamp(input logic [31:0] v);
    if (v[12:0] < wrac_pkg::NAVG_MIN || v[31:13] != '0) begin
      return (v[31:13] != '0) ? wrac_pkg::NAVG_MAX : wrac_pkg::NAVG_MIN;
    end
    return v[12:0] > wrac_pkg::NAVG_MAX ? wrac_pkg::NAVG_MAX : v[12:0];
  endfunction

  wire logic force_off = wb_wr && (wb_adr_i == wrac_pkg::ADDR_CTRL)
                         && (wb_dat_i[wrac_pkg::CTRL_DEFAULT_BIT]
                             || wb_dat_i[wrac_pkg::CTRL_ASCALE_BIT]);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= wrac_pkg::CTRL_RESET[10:0];
    end else if (wb_wr && wb_adr_i == wrac_pkg::ADDR_CTRL) begin
      ctrl_q      <= {1'b0, 2'b00, wb_dat_i[7:0]};
      if (force_off) begin
        ctrl_q[wrac_pkg::CTRL_COMPL_BIT] <= 1'b0;
      end
      ctrl_q[wrac_pkg::CTRL_CLEAR_BIT] <= wb_dat_i[wrac_pkg::CTRL_CLEAR_BIT];
    end else begin
      ctrl_q[wrac_pkg::CTRL_CLEAR_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      navg_q    <= wrac_pkg::NAVG_RESET;
      len_req_q <= wrac_pkg::LEN_RESET;
      compl_q   <= wrac_pkg::COMPL_RESET;
      screen_q  <= wrac_pkg::SCREEN_RESET;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        wrac_pkg::ADDR_NAVG:   navg_q    <= wrac_navg_clamp(wb_dat_i);
        wrac_pkg::ADDR_LEN:    len_req_q <= wb_dat_i[18:0];
        // Compare the whole word so that values above 127 still clamp to 100
        wrac_pkg::ADDR_COMPL:  compl_q   <= (wb_dat_i > 32'(wrac_pkg::COMPL_FULL))
                                            ? wrac_pkg::COMPL_FULL : wb_dat_i[6:0];
        wrac_pkg::ADDR_SCREEN: screen_q  <= wb_dat_i[18:0];
        default: ;
      endcase
    end
  end

  wire logic        etime   = ctrl_q[wrac_pkg::CTRL_ETIME_BIT];
  wire logic        deep    = ctrl_q[wrac_pkg::CTRL_DEEP_BIT];
  wire logic        autolen = ctrl_q[wrac_pkg::CTRL_AUTOLEN_BIT];
  wire logic [1:0]  wcode   = ctrl_q[wrac_pkg::CTRL_WIDTH_LSB +: 2];
  wire logic        avg_on  = ctrl_q[wrac_pkg::CTRL_AVG_BIT] && etime;
  wire logic        compl_on = ctrl_q[wrac_pkg::CTRL_COMPL_BIT];

  // ==========================================================================
  // Record length selection
  logic [18:0] max_len;
  logic [18:0] single_max;
  logic [18:0] floor_len;
  logic [18:0] act_len;
  logic [18:0] single_len;

  always_comb begin
    single_max = deep ? wrac_pkg::LEN_SINGLE_DEEP : wrac_pkg::LEN_SINGLE_BASE;
    unique case (wcode)
      wrac_pkg::WRAC_DOUBLE_TYPE_W: begin
        max_len   = deep ? wrac_pkg::LEN_DOUBLE_DEEP : wrac_pkg::LEN_DOUBLE_BASE;
        floor_len = wrac_pkg::LEN_AUTO_DOUBLE;
      end
      wrac_pkg::WRAC_QUAD_TYPE_W: begin
        max_len   = deep ? wrac_pkg::LEN_QUAD_DEEP : wrac_pkg::LEN_QUAD_BASE;
        floor_len = wrac_pkg::LEN_AUTO_DOUBLE;
      end
      default: begin
        // Deep single manual limit is 65K points, i.e. the 64K slot memory
        max_len   = single_max;
        floor_len = wrac_pkg::LEN_AUTO_SINGLE;
      end
    endcase
    if (autolen && ctrl_q[wrac_pkg::CTRL_GRADED_BIT]) begin
      act_len = wrac_clamp(wrac_pkg::LEN_GRADED_OPT, floor_len, max_len);
    end else if (autolen) begin
      act_len = wrac_clamp(screen_q, floor_len, max_len);
    end else begin
      act_len = wrac_clamp(len_req_q, wrac_pkg::LEN_MANUAL_MIN, max_len);
    end
    // Single-width companion follows up to its own maximum, then stays clamped
    single_len = (act_len > single_max) ? single_max : act_len;
  end

  // Bins tracked by the store are the first BINS points of the record
  wire logic [18:0] bins_used = (act_len > 19'(BINS)) ? 19'(BINS) : act_len;

  // ==========================================================================
  // Acquisition and completion
  wrac_pkg::wrac_state_type state_q;
  logic [18:0] qual_q;
  logic [AW-1:0] clr_idx_q;
  logic        meas_q;

  // Threshold compare without division: qual*100 >= pct*bins_used
  wire logic [25:0] qual_scaled = 26'(qual_q) * 26'(wrac_pkg::COMPL_FULL);
  wire logic [25:0] thr_scaled  = 26'(compl_q) * 26'(bins_used);
  wire logic        compl_eff   = compl_on && etime;
  wire logic        reached     = compl_eff ? (qual_scaled >= thr_scaled)
                                            : cycle_end_i;
  wire logic [12:0] need_cnt    = avg_on ? navg_q : 13'h0001;

  wire logic accept = smp_valid_i && smp_ready_o
                      && (32'(smp_bin_i) < 32'(bins_used));
  logic [12:0] new_cnt;
  logic [DW-1:0] new_val;

  always_comb begin
    new_cnt = (bin.rcnt < need_cnt) ? bin.rcnt + 13'h0001 : bin.rcnt;
    // Running mean with weight 1/n, n growing to the configured count
    new_val = bin.rdata;
    if (avg_on && bin.rcnt != 13'h0000) begin
      new_val = DW'($signed({1'b0, bin.rdata})
                    + ($signed({1'b0, smp_data_i}) - $signed({1'b0, bin.rdata}))
                      / $signed({1'b0, new_cnt}));
    end else begin
      new_val = smp_data_i;
    end
  end

  assign bin.addr  = (state_q == wrac_pkg::WRAC_CLEAR_TYPE_S) ? clr_idx_q : smp_bin_i;
  assign bin.wr    = accept;
  assign bin.wdata = new_val;
  assign bin.wcnt  = new_cnt;
  assign bin.clr   = (state_q == wrac_pkg::WRAC_CLEAR_TYPE_S);
  assign smp_ready_o = (state_q == wrac_pkg::WRAC_ACQ_TYPE_S);

  wire logic qualifies = accept && (bin.rcnt < need_cnt) && (new_cnt == need_cnt);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= wrac_pkg::WRAC_IDLE_TYPE_S;
      qual_q    <= '0;
      clr_idx_q <= '0;
      meas_q    <= 1'b0;
    end else begin
      meas_q <= 1'b0;
      unique case (state_q)
        wrac_pkg::WRAC_IDLE_TYPE_S: begin
          state_q <= wrac_pkg::WRAC_ACQ_TYPE_S;
        end
        wrac_pkg::WRAC_ACQ_TYPE_S: begin
          // Triggers with no samples simply leave the count unchanged
          if (qualifies) begin
            qual_q <= qual_q + 19'h00001;
          end
          if (ctrl_q[wrac_pkg::CTRL_CLEAR_BIT]) begin
            state_q <= wrac_pkg::WRAC_CLEAR_TYPE_S;
          end else if (compl_eff && reached && qual_q != '0) begin
            meas_q  <= 1'b1;
            state_q <= wrac_pkg::WRAC_CLEAR_TYPE_S;
          end else if (!compl_eff && cycle_end_i) begin
            meas_q <= 1'b1;
          end
        end
        wrac_pkg::WRAC_CLEAR_TYPE_S: begin
          qual_q  <= '0;
          state_q <= wrac_pkg::WRAC_ACQ_TYPE_S;
        end
        default: state_q <= wrac_pkg::WRAC_IDLE_TYPE_S;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rel_cnt_q <= '0;
    end else if (meas_q) begin
      rel_cnt_q <= rel_cnt_q + 32'h0000_0001;
    end
  end

  assign meas_o       = meas_q;
  assign avg_active_o = avg_on;

  // ==========================================================================
  // Wishbone slave: one-cycle ack, error on unmapped address
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_err_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= 1'b0;
      wb_err_q <= 1'b0;
      if (wb_req) begin
        wb_ack_q <= 1'b1;
        unique case (wb_adr_i)
          wrac_pkg::ADDR_CTRL:   wb_dat_q <= {21'h0, 3'b000, ctrl_q[7:0]};
          wrac_pkg::ADDR_NAVG:   wb_dat_q <= {19'h0, navg_q};
          wrac_pkg::ADDR_LEN:    wb_dat_q <= {13'h0, len_req_q};
          wrac_pkg::ADDR_COMPL:  wb_dat_q <= {25'h0, compl_q};
          wrac_pkg::ADDR_SCREEN: wb_dat_q <= {13'h0, screen_q};
          wrac_pkg::ADDR_STATUS: wb_dat_q <= {28'h0, avg_on, compl_eff, state_q};
          wrac_pkg::ADDR_ACTLEN: wb_dat_q <= {single_len[15:0], act_len[15:0]};
          wrac_pkg::ADDR_QUAL:   wb_dat_q <= {13'h0, qual_q};
          wrac_pkg::ADDR_RELCNT: wb_dat_q <= rel_cnt_q;
          default: begin
            wb_ack_q <= 1'b0;
            wb_err_q <= 1'b1;
            wb_dat_q <= '0;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_err_o = wb_err_q;
  assign wb_dat_o = wb_dat_q;
endmodule

// ---- bench/wrac_stream_model.sv ----
// Sample source and measurement counter standing at the far side of the controller
`timescale 1ns/100ps
module wrac_stream_model #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          smp_ready_i,
  input  wire logic          meas_i,
  output logic               smp_valid_o,
  output logic [AW-1:0]      smp_bin_o,
  output logic [DW-1:0]      smp_data_o,
  output logic [15:0]        meas_cnt_o
);
  initial begin
    smp_valid_o = 1'b0;
    smp_bin_o = '0;
    smp_data_o = '0;
  end

  // ==========================================================================
  // One sample, held until taken; gap cycles model a slow digitizer
  task automatic send(input logic [AW-1:0] b, input logic [DW-1:0] d, input int gap);
    repeat (gap) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    smp_valid_o <= 1'b1;
    smp_bin_o <= b;
    smp_data_o <= d;
    @(negedge sys_clk_i);
    while (smp_ready_i !== 1'b1) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    smp_valid_o <= 1'b0;
    // Released lines never keep the last value
    smp_bin_o <= ~b;
    smp_data_o <= ~d;
  endtask

  // ==========================================================================
  // Measurement engine: counts released measurements
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      meas_cnt_o <= 16'h0000;
    else if (meas_i)
      meas_cnt_o <= meas_cnt_o + 16'h0001;
  end
endmodule

// ---- bench/wrac_top_sva.sv ----
// Checker for the register port, release timing and averaging flag
`timescale 1ns/100ps
module wrac_top_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        cycle_end_i,
  input wire logic        smp_ready_o,
  input wire logic        meas_o,
  input wire logic        avg_active_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Shadow of ET, averaging and completion bits
  logic [2:0] ctrl_q;
  logic       wr_ctrl;
  logic       cmp_on;
  logic       avg_on;
  // Follows the slave, which stores a write at the edge that takes the request
  assign wr_ctrl = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_we_i
                   && wb_sel_i == 4'hf && wb_adr_i == wrac_pkg::ADDR_CTRL;
  assign cmp_on = ctrl_q[2] & ctrl_q[0];
  assign avg_on = ctrl_q[1] & ctrl_q[0];
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      ctrl_q <= wrac_pkg::CTRL_RESET[2:0];
    else if (wr_ctrl)
      ctrl_q <= {wb_dat_i[2] & ~wb_dat_i[8] & ~wb_dat_i[9], wb_dat_i[1:0]};
  end
  // ==========================================================================
  // Properties
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("no answer one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_err_map;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i > 8'h20 |=> wb_err_o && !wb_ack_o;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_excl;
    !(wb_ack_o && wb_err_o);
  endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");
  property p_clear;
    meas_o && !$past(cycle_end_i) |-> ##[0:2] !smp_ready_o;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear cycle after release");
  property p_avg;
    $stable(avg_on) |-> avg_active_o == avg_on;
  endproperty
  a_avg: assert property (p_avg) else $error("averaging flag wrong");
  property p_ready_up;
    $fell(rst_i) |-> ##[1:2] smp_ready_o;
  endproperty
  a_ready_up: assert property (p_ready_up) else $error("ready late after reset");
  property p_rel_cycle;
    cycle_end_i && !cmp_on && $stable(cmp_on) |=> meas_o;
  endproperty
  a_rel_cycle: assert property (p_rel_cycle) else $error("no release at cycle end");
endmodule

bind wrac_top wrac_top_chk wrac_top_chk_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cycle_end_i(cycle_end_i),
  .smp_ready_o(smp_ready_o), .meas_o(meas_o), .avg_active_o(avg_active_o)
);

// ---- bench/wrac_top_test.sv ----
// Self-checking testbench of the record acquisition controller
`timescale 1ns/100ps
module wrac_top_test;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq;
  logic wb_ack_o, wb_err_o, re, trig_i = 1'b0, cycle_end_i = 1'b0;
  logic smp_valid_i, smp_ready_o, meas_o, avg_active_o;
  logic [7:0]  smp_bin_i;
  logic [15:0] smp_data_i, mc, mb;
  int bad_count = 0, compares = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  wrac_top wrac_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .trig_i(trig_i), .cycle_end_i(cycle_end_i), .smp_valid_i(smp_valid_i),
    .smp_bin_i(smp_bin_i), .smp_data_i(smp_data_i), .smp_ready_o(smp_ready_o),
    .meas_o(meas_o), .avg_active_o(avg_active_o));
  wrac_stream_model wrac_stream_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .smp_ready_i(smp_ready_o), .meas_i(meas_o), .smp_valid_o(smp_valid_i),
    .smp_bin_o(smp_bin_i), .smp_data_o(smp_data_i), .meas_cnt_o(mc));
  // ==========================================================================
  // Bus and compare tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    @(negedge sys_clk_i);
    while (!(wb_ack_o || wb_err_o)) begin
      @(negedge sys_clk_i);
      n++;
    end
    re = wb_err_o;
    @(posedge sys_clk_i);
    rq = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, rq & m);
  endtask
  task automatic pulse_end;
    @(posedge sys_clk_i);
    cycle_end_i <= 1'b1;
    @(posedge sys_clk_i);
    cycle_end_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] tb [7][3] = '{'{8'h04, 0, 1}, '{8'h04, 5000, 32'h1000}, '{8'h0c, 150, 32'h64},
      '{8'h08, 5, 32'h5}, '{8'h08, 20000, 32'h4e20}, '{8'h08, 16, 32'h10}, '{8'h04, 4096, 32'h1000}};
    rc("ctrl", wrac_pkg::ADDR_CTRL, '1, 32'(wrac_pkg::CTRL_RESET));
    rc("navg", wrac_pkg::ADDR_NAVG, '1, 32'(wrac_pkg::NAVG_RESET));
    rc("len", wrac_pkg::ADDR_LEN, '1, 32'(wrac_pkg::LEN_RESET));
    rc("compl", wrac_pkg::ADDR_COMPL, '1, 32'(wrac_pkg::COMPL_RESET));
    rc("screen", wrac_pkg::ADDR_SCREEN, '1, 32'(wrac_pkg::SCREEN_RESET));
    foreach (tb[i]) begin
      wb(1'b1, tb[i][0][7:0], tb[i][1], 4'hf);
      rc("clamp", tb[i][0][7:0], '1, tb[i][2]);
    end
    wb(1'b1, wrac_pkg::ADDR_NAVG, 32'h7, 4'h3);
    rc("navg sel", wrac_pkg::ADDR_NAVG, '1, 32'h1000);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    chk("err", 32'h1, {31'h0, re});
    $display("test regs done");
  endtask
  task automatic t_len;
    logic [31:0] lt [9][4] = '{'{32'h9, 16, 100, 32'h0100_0100},
      '{32'h49, 16, 100, 32'h0200_0200}, '{32'h9, 16, 20000, 32'h4000_4000},
      '{32'h29, 16, 100, 32'h0800_0800}, '{32'h41, 40000, 100, 32'h4000_8000},
      '{32'h81, 60000, 100, 32'h4000_ea60}, '{32'h11, 70000, 100, 32'h0000_0000},
      '{32'h1, 20000, 100, 32'h4000_4000}, '{32'h51, 70000, 100, 32'h0000_1170}};
    foreach (lt[i]) begin
      wb(1'b1, wrac_pkg::ADDR_CTRL, lt[i][0], 4'hf);
      wb(1'b1, wrac_pkg::ADDR_SCREEN, lt[i][2], 4'hf);
      wb(1'b1, wrac_pkg::ADDR_LEN, lt[i][1], 4'hf);
      rc("actlen", wrac_pkg::ADDR_ACTLEN, '1, lt[i][3]);
    end
    $display("test length done");
  endtask
  task automatic t_compl;
    logic [31:0] rb;
    wb(1'b1, wrac_pkg::ADDR_COMPL, 32'd100, 4'hf);
    wb(1'b1, wrac_pkg::ADDR_LEN, 32'd16, 4'hf);
    wb(1'b1, wrac_pkg::ADDR_CTRL, 32'h405, 4'hf);
    rc("relcnt", wrac_pkg::ADDR_RELCNT, '1, 32'h0);
    rb = rq;
    mb = mc;
    for (int i = 0; i < 15; i++) wrac_stream_model_i.send(8'(i), 16'(i * 7), i % 3);
    trig_i <= 1'b1;
    @(posedge sys_clk_i) trig_i <= 1'b0;
    wrac_stream_model_i.send(8'd3, 16'h55, 0);
    wrac_stream_model_i.send(8'd40, 16'h66, 0);
    repeat (3) @(posedge sys_clk_i);
    rc("qual", wrac_pkg::ADDR_QUAL, '1, 32'd15);
    chk("meas", {16'h0, mb}, {16'h0, mc});
    wrac_stream_model_i.send(8'd15, 16'h77, 0);
    repeat (6) @(posedge sys_clk_i);
    chk("meas", {16'h0, mb + 16'h1}, {16'h0, mc});
    rc("qual", wrac_pkg::ADDR_QUAL, '1, 32'd0);
    rc("relcnt", wrac_pkg::ADDR_RELCNT, '1, rb + 32'h1);
    $display("test completion done");
  endtask
  task automatic t_avg;
    wb(1'b1, wrac_pkg::ADDR_NAVG, 32'd2, 4'hf);
    wb(1'b1, wrac_pkg::ADDR_CTRL, 32'h407, 4'hf);
    repeat (2) @(posedge sys_clk_i);
    chk("avg", 32'h1, {31'h0, avg_active_o});
    rc("status", wrac_pkg::ADDR_STATUS, '1, 32'hd);
    wrac_stream_model_i.send(8'd0, 16'h100, 0);
    rc("qual", wrac_pkg::ADDR_QUAL, '1, 32'd0);
    wrac_stream_model_i.send(8'd0, 16'h50, 2);
    repeat (3) @(posedge sys_clk_i);
    rc("qual", wrac_pkg::ADDR_QUAL, '1, 32'd1);
    wb(1'b1, wrac_pkg::ADDR_CTRL, 32'h6, 4'hf);
    repeat (2) @(posedge sys_clk_i);
    chk("avg", 32'h0, {31'h0, avg_active_o});
    rc("status", wrac_pkg::ADDR_STATUS, '1, 32'h1);
    mb = mc;
    pulse_end();
    chk("meas", {16'h0, mb + 16'h1}, {16'h0, mc});
    $display("test averaging done");
  endtask
  task automatic t_off;
    wb(1'b1, wrac_pkg::ADDR_CTRL, 32'h105, 4'hf);
    rc("compl bit", wrac_pkg::ADDR_CTRL, 32'h4, 32'h0);
    mb = mc;
    pulse_end();
    pulse_end();
    chk("meas", {16'h0, mb + 16'h2}, {16'h0, mc});
    wb(1'b1, wrac_pkg::ADDR_CTRL, 32'h205, 4'hf);
    rc("compl bit", wrac_pkg::ADDR_CTRL, 32'h4, 32'h0);
    $display("test off done");
  endtask
  // ==========================================================================
  // Run and verdict
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_len();
    t_compl();
    t_avg();
    t_off();
    test_done();
  end
endmodule
